// File: verilog/servo_alarm_params.svh
// constants for the servo protective sequence: offsets, field positions, reset values
// Function
// - normal state: alarm transistor on, code lines open
// - parameter, encoder, reference faults: code 000
// - overcurrent or drive overheat: line a only
// - regeneration or position overflow: lines a, b
// - dc bus overvoltage: line c only
// - overspeed: lines a and c
// - overrun or encoder disconnect: as overspeed
// - motor or drive overload: all three lines
// - heat sink overheat: all three lines
// - phase, power loss, contactor: line b only
// - low fault clear input clears latched alarm
// - control power loss discards alarm state
// - panel reset command also clears alarm
// - servo-on input low energises the motor
// - servo-on input high de-energises the motor
// - bypass bit 1 forces servo on unless an alarm is latched
// - alarm output closed normal, open on alarm
`ifndef SERVO_ALARM_PARAMS_SVH
`define SERVO_ALARM_PARAMS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CAUSE 8'h08
`define REG_ADDR_W 8
`define REG_DATA_W 32

// control register fields
`define CTRL_BYPASS_BIT 0
`define CTRL_RESET 32'h0000_0000

// status register fields
`define STAT_CODE_LSB 0
`define STAT_ALARM_BIT 3
`define STAT_FAULT_OUT_BIT 4
`define STAT_ENERGISE_BIT 5
`define STAT_PANEL_BIT 6

// alarm cause vector positions
`define CAUSE_PARAM 0
`define CAUSE_ABS_ENC 1
`define CAUSE_REF_READ 2
`define CAUSE_OVERCUR 3
`define CAUSE_DRV_HOT 4
`define CAUSE_REGEN 5
`define CAUSE_POS_OVF 6
`define CAUSE_OVERVOLT 7
`define CAUSE_OVERSPEED 8
`define CAUSE_OVERRUN 9
`define CAUSE_ENC_OPEN 10
`define CAUSE_OVERLOAD 11
`define CAUSE_SINK_HOT 12
`define CAUSE_OPEN_PHASE 13
`define CAUSE_PWR_LOSS 14
`define CAUSE_CONTACTOR 15
`define CAUSE_COUNT 16

// code line patterns {c, b, a}, bit set = transistor on
`define CODE_NONE 3'h0
`define CODE_PARAM 3'h0
`define CODE_OVERCUR 3'h1
`define CODE_REGEN 3'h3
`define CODE_OVERVOLT 3'h4
`define CODE_OVERSPEED 3'h5
`define CODE_OVERLOAD 3'h7
`define CODE_POWER 3'h2

// synchroniser depth and idle level of active-low pins
`define SYNC_STAGES 3
`define PIN_IDLE 1'b1

`endif

// File: verilog/servo_alarm_pkg.sv
// types shared by the servo protective sequence modules
package servo_alarm_pkg;

    // sequence states, gray coded along normal -> alarm -> clearing
    typedef enum logic [1:0] {
        ST_NORMAL = 2'h0,
        ST_ALARM = 2'h1,
        ST_CLEARING = 2'h3
    } seq_mode_t;

    // whole register state of the sequence module
    typedef struct packed {
        seq_mode_t mode;
        logic [2:0] code;
        logic fault_out;
        logic energise;
        logic panel_fault;
        logic bypass;
        logic [15:0] cause_seen;
        logic [31:0] rdata;
    } seq_state_t;

endpackage : servo_alarm_pkg

// File: verilog/fault_enc_if.sv
// carrier between the sequence module and the fault encoder
`timescale 1ns/10ps
interface fault_enc_if #(parameter int CAUSE_W = 16) (
    input wire logic clk_sys,
    input wire logic rstn
);
    logic [CAUSE_W-1:0] cause;
    logic [2:0] code;
    logic any_fault;

    modport enc (input clk_sys, input rstn, input cause, output code, output any_fault);
    modport seq (output cause, input code, input any_fault);
endinterface : fault_enc_if

// File: verilog/pin_sync.sv
// three-stage synchroniser with agreement filter for a contact input pin
`timescale 1ns/10ps
`include "servo_alarm_params.svh"
module pin_sync #(
    parameter int STAGES = `SYNC_STAGES,
    parameter logic RST_VAL = `PIN_IDLE
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pin_in,
    output logic level
);
    typedef struct packed {
        logic [STAGES-1:0] chain;
        logic level;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    if (STAGES < 3) begin : g_chk
        $error("pin_sync needs at least three stages");
    end

    // the level moves only once the last two stages agree
    always_comb begin
        nxt_st = st_ff;
        nxt_st.chain = {st_ff.chain[STAGES-2:0], pin_in};
        if (st_ff.chain[STAGES-1] == st_ff.chain[STAGES-2]) begin
            nxt_st.level = st_ff.chain[STAGES-1];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{chain: {STAGES{RST_VAL}}, level: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.level;
endmodule : pin_sync

// File: verilog/fault_encoder.sv
// maps the detected alarm causes to a code line pattern
`timescale 1ns/10ps
`include "servo_alarm_params.svh"
module fault_encoder #(
    parameter int CAUSE_W = `CAUSE_COUNT
) (
    fault_enc_if.enc bus
);
    import servo_alarm_pkg::*;

    if (CAUSE_W != `CAUSE_COUNT) begin : g_chk
        $error("fault_encoder serves exactly the documented cause set");
    end

    // highest-severity group wins when several causes arrive together
    function automatic logic [2:0] encode(input logic [CAUSE_W-1:0] c);
        logic [2:0] r;
        r = `CODE_NONE;
        if (c[`CAUSE_OPEN_PHASE] | c[`CAUSE_PWR_LOSS] | c[`CAUSE_CONTACTOR]) begin
            r = `CODE_POWER;
        end
        if (c[`CAUSE_REGEN] | c[`CAUSE_POS_OVF]) begin
            r = `CODE_REGEN;
        end
        if (c[`CAUSE_OVERLOAD] | c[`CAUSE_SINK_HOT]) begin
            r = `CODE_OVERLOAD;
        end
        if (c[`CAUSE_OVERSPEED] | c[`CAUSE_OVERRUN] | c[`CAUSE_ENC_OPEN]) begin
            r = `CODE_OVERSPEED;
        end
        if (c[`CAUSE_OVERVOLT]) begin
            r = `CODE_OVERVOLT;
        end
        if (c[`CAUSE_OVERCUR] | c[`CAUSE_DRV_HOT]) begin
            r = `CODE_OVERCUR;
        end
        if (c[`CAUSE_PARAM] | c[`CAUSE_ABS_ENC] | c[`CAUSE_REF_READ]) begin
            r = `CODE_PARAM;
        end
        return r;
    endfunction : encode

    assign bus.code = encode(bus.cause);
    assign bus.any_fault = |bus.cause;

    property p_code_param;
        @(posedge bus.clk_sys) disable iff (!bus.rstn)
        (bus.cause[`CAUSE_ABS_ENC] || bus.cause[`CAUSE_REF_READ]) |-> bus.code == 3'h0;
    endproperty
    a_code_param: assert property (p_code_param) else $error("param group code wrong");

    property p_code_overcur;
        @(posedge bus.clk_sys) disable iff (!bus.rstn)
        (bus.cause == 16'h0010) |-> bus.code == 3'h1;
    endproperty
    a_code_overcur: assert property (p_code_overcur) else $error("overheat code wrong");

    property p_code_overspeed;
        @(posedge bus.clk_sys) disable iff (!bus.rstn)
        (bus.cause == 16'h0400 || bus.cause == 16'h0100) |-> bus.code == 3'h5;
    endproperty
    a_code_overspeed: assert property (p_code_overspeed) else $error("speed code");

    property p_code_power;
        @(posedge bus.clk_sys) disable iff (!bus.rstn)
        (bus.cause == 16'h4000) |-> bus.code == 3'h2 && bus.any_fault;
    endproperty
    a_code_power: assert property (p_code_power) else $error("power code wrong");
endmodule : fault_encoder

// File: verilog/servo_alarm_seq.sv
// protective sequence: alarm latch, code lines, servo alarm line and motor enable
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "servo_alarm_params.svh"
module servo_alarm_seq #(
    parameter int CAUSE_W = `CAUSE_COUNT
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [CAUSE_W-1:0] alarm_cause,
    input wire logic panel_clear_req,
    input wire logic panel_link_fault,
    input wire logic fault_clear_in_n,
    input wire logic energise_in_n,
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [`REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`REG_DATA_W-1:0] reg_rdata,
    output logic fault_code_line_a,
    output logic fault_code_line_b,
    output logic fault_code_line_c,
    output logic servo_fault_out,
    output logic motor_energise,
    output logic panel_fault_display
);
    import servo_alarm_pkg::*;

    // reset control word
    localparam logic [`REG_DATA_W-1:0] CTRL_RST = `CTRL_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (CAUSE_W != `CAUSE_COUNT) begin : g_chk_cause
        $error("servo_alarm_seq serves exactly the documented cause set");
    end
    if (`REG_DATA_W < CAUSE_W) begin : g_chk_width
        $error("register data too narrow for the cause snapshot");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and the fault encoder

    logic clear_lvl_n;
    logic son_lvl_n;

    // the host contact inputs are asynchronous to the control clock
    pin_sync #(
        .STAGES(`SYNC_STAGES),
        .RST_VAL(`PIN_IDLE)
    ) u_clear_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in(fault_clear_in_n),
        .level(clear_lvl_n)
    );

    pin_sync #(
        .STAGES(`SYNC_STAGES),
        .RST_VAL(`PIN_IDLE)
    ) u_son_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in(energise_in_n),
        .level(son_lvl_n)
    );

    fault_enc_if #(.CAUSE_W(CAUSE_W)) enc_bus (
        .clk_sys(clk_sys),
        .rstn(rstn)
    );

    fault_encoder #(.CAUSE_W(CAUSE_W)) u_enc (
        .bus(enc_bus)
    );

    // detectors sit on this clock, so their causes need no synchroniser
    assign enc_bus.cause = alarm_cause;

    ////////////////////////////////////////////////////////////////////////////
    // register read image

    function automatic logic [`REG_DATA_W-1:0] read_word(
        input logic [`REG_ADDR_W-1:0] a,
        input seq_state_t s
    );
        logic [`REG_DATA_W-1:0] w;
        w = '0;
        case (a)
            `REG_CTRL: begin
                w[`CTRL_BYPASS_BIT] = s.bypass;
            end
            `REG_STATUS: begin
                w[`STAT_CODE_LSB +: 3] = s.code;
                w[`STAT_ALARM_BIT] = (s.mode != ST_NORMAL);
                w[`STAT_FAULT_OUT_BIT] = s.fault_out;
                w[`STAT_ENERGISE_BIT] = s.energise;
                w[`STAT_PANEL_BIT] = s.panel_fault;
            end
            `REG_CAUSE: begin
                w[CAUSE_W-1:0] = s.cause_seen;
            end
            default: begin
                w = '0; // unmapped offsets read as zero
            end
        endcase
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////
    // next state

    seq_state_t st_ff;
    seq_state_t nxt_st;
    logic clear_req;
    logic alarm_next;

    // either reset source asks for a clear; the panel command is a pulse
    assign clear_req = !clear_lvl_n || panel_clear_req;

    always_comb begin
        nxt_st = st_ff;
        alarm_next = 1'b0;

        // bypass bit steers whether the servo-on pin is honoured
        if (reg_wr && reg_addr == `REG_CTRL) begin
            nxt_st.bypass = reg_wdata[`CTRL_BYPASS_BIT];
        end

        case (st_ff.mode)
            ST_NORMAL: begin
                if (enc_bus.any_fault) begin
                    nxt_st.mode = ST_ALARM;
                    nxt_st.code = enc_bus.code;
                    nxt_st.cause_seen = alarm_cause;
                end
            end
            ST_ALARM: begin
                // code is frozen at the first fault; later causes only add to the snapshot
                nxt_st.cause_seen = st_ff.cause_seen | alarm_cause;
                if (clear_req) begin
                    nxt_st.mode = ST_CLEARING;
                end
            end
            ST_CLEARING: begin
                // a cause still present wins over the clear and relatches at once
                if (enc_bus.any_fault) begin
                    nxt_st.mode = ST_ALARM;
                    nxt_st.code = enc_bus.code;
                    nxt_st.cause_seen = alarm_cause;
                end else begin
                    nxt_st.mode = ST_NORMAL;
                    nxt_st.code = `CODE_NONE;
                    nxt_st.cause_seen = '0;
                end
            end
            default: begin
                nxt_st.mode = ST_ALARM;
            end
        endcase

        alarm_next = (nxt_st.mode != ST_NORMAL);

        // normal state closes the alarm transistor and opens every code line
        nxt_st.fault_out = !alarm_next;
        if (!alarm_next) begin
            nxt_st.code = `CODE_NONE;
        end

        // motor enable: alarm forces off, else bypass or low servo-on pin
        if (alarm_next) begin
            nxt_st.energise = 1'b0;
        end else if (nxt_st.bypass) begin
            nxt_st.energise = 1'b1;
        end else begin
            nxt_st.energise = !son_lvl_n;
        end

        // a broken panel link touches only the panel indicator
        nxt_st.panel_fault = panel_link_fault;

        nxt_st.rdata = reg_rd ? read_word(reg_addr, st_ff) : '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; power-up reset starts with no alarm

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{
                mode: ST_NORMAL,
                code: `CODE_NONE,
                fault_out: 1'b1,
                energise: 1'b0,
                panel_fault: 1'b0,
                bypass: CTRL_RST[`CTRL_BYPASS_BIT],
                cause_seen: '0,
                rdata: '0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state register

    assign fault_code_line_a = st_ff.code[0];
    assign fault_code_line_b = st_ff.code[1];
    assign fault_code_line_c = st_ff.code[2];
    assign servo_fault_out = st_ff.fault_out;
    assign motor_energise = st_ff.energise;
    assign panel_fault_display = st_ff.panel_fault;
    assign reg_rdata = st_ff.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    // defaults for bare properties
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_fault_seen;
        enc_bus.any_fault && st_ff.mode == ST_NORMAL;
    endsequence

    sequence s_clear_clean;
        st_ff.mode == ST_ALARM && clear_req ##1 !enc_bus.any_fault;
    endsequence

    property p_normal_lines;
        @(posedge clk_sys) disable iff (!rstn)
        servo_fault_out |-> !fault_code_line_a && !fault_code_line_b && !fault_code_line_c;
    endproperty
    a_normal_lines: assert property (p_normal_lines) else $error("lines on while normal");

    property p_latch_code;
        logic [2:0] c;
        @(posedge clk_sys) disable iff (!rstn)
        (s_fault_seen, c = enc_bus.code) |=> !servo_fault_out
            && {fault_code_line_c, fault_code_line_b, fault_code_line_a} == c;
    endproperty
    a_latch_code: assert property (p_latch_code) else $error("fault not latched");

    property p_hold;
        @(posedge clk_sys) disable iff (!rstn)
        (st_ff.mode == ST_ALARM && !clear_req) |=> st_ff.mode == ST_ALARM
            && $stable(st_ff.code) && !servo_fault_out;
    endproperty
    a_hold: assert property (p_hold) else $error("alarm dropped without clear");

    property p_clear;
        @(posedge clk_sys) disable iff (!rstn)
        s_clear_clean |=> servo_fault_out && st_ff.code == 3'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not release alarm");

    property p_clear_pin;
        @(posedge clk_sys) disable iff (!rstn)
        (st_ff.mode == ST_ALARM && !alarm_cause[0] && $fell(fault_clear_in_n)) ##0
            (!fault_clear_in_n && !enc_bus.any_fault) [*5] |-> ##[0:2] servo_fault_out;
    endproperty
    a_clear_pin: assert property (p_clear_pin) else $error("pin clear too slow");

    property p_panel_clear;
        @(posedge clk_sys) disable iff (!rstn)
        (st_ff.mode == ST_ALARM && panel_clear_req ##1 !enc_bus.any_fault)
            |=> servo_fault_out;
    endproperty
    a_panel_clear: assert property (p_panel_clear) else $error("panel clear ignored");

    property p_no_energise_in_alarm;
        @(posedge clk_sys) disable iff (!rstn)
        !servo_fault_out |-> !motor_energise;
    endproperty
    a_no_energise_in_alarm: assert property (p_no_energise_in_alarm)
        else $error("motor on in alarm");

    property p_bypass_on;
        @(posedge clk_sys) disable iff (!rstn)
        (nxt_st.bypass && nxt_st.mode == ST_NORMAL) |=> motor_energise;
    endproperty
    a_bypass_on: assert property (p_bypass_on) else $error("bypass did not force on");

    property p_son_low;
        @(posedge clk_sys) disable iff (!rstn)
        (!son_lvl_n && !st_ff.bypass && nxt_st.mode == ST_NORMAL) |=> motor_energise;
    endproperty
    a_son_low: assert property (p_son_low) else $error("servo-on low not honoured");

    property p_son_high;
        @(posedge clk_sys) disable iff (!rstn)
        (son_lvl_n && !nxt_st.bypass) |=> !motor_energise;
    endproperty
    a_son_high: assert property (p_son_high) else $error("servo-off not honoured");

    property p_panel_flag;
        @(posedge clk_sys) disable iff (!rstn)
        (panel_link_fault && st_ff.mode == ST_NORMAL && !enc_bus.any_fault)
            |=> panel_fault_display && $stable(fault_code_line_a);
    endproperty
    a_panel_flag: assert property (p_panel_flag) else $error("panel flag wrong");

    property p_read_latency;
        @(posedge clk_sys) disable iff (!rstn)
        (reg_rd && reg_addr == `REG_STATUS) |=> reg_rdata[4] == $past(servo_fault_out);
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("status read wrong");

    sequence s_clear_blocked;
        st_ff.mode == ST_CLEARING && enc_bus.any_fault;
    endsequence

    property p_relatch;
        logic [2:0] c;
        (s_clear_blocked, c = enc_bus.code)
            |=> !servo_fault_out && st_ff.code == c;
    endproperty
    a_relatch: assert property (p_relatch) else $error("relatch lost");

    property p_clearing_brief;
        st_ff.mode == ST_CLEARING |=> st_ff.mode != ST_CLEARING;
    endproperty
    a_clearing_brief: assert property (p_clearing_brief) else $error("stuck clearing");

    property p_cause_kept;
        st_ff.mode == ST_ALARM
            |=> (st_ff.cause_seen & $past(alarm_cause)) == $past(alarm_cause);
    endproperty
    a_cause_kept: assert property (p_cause_kept) else $error("snapshot lost");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray data");

    // power-up start is checked through reset values of the state register
    property p_reset_clean;
        @(posedge clk_sys) $rose(rstn) |-> servo_fault_out && !motor_energise;
    endproperty
    a_reset_clean: assert property (p_reset_clean) else $error("alarm survived power-up");
endmodule : servo_alarm_seq

// File: sim/host_ctrl_model.sv
// host controller model: drives the contact inputs and watches the alarm outputs
`timescale 1ns/10ps
module host_ctrl_model (
    input wire logic clk_sys,
    input wire logic want_on,
    input wire logic want_clear,
    input wire logic servo_fault_out,
    input wire logic fault_code_line_a,
    input wire logic fault_code_line_b,
    input wire logic fault_code_line_c,
    output logic energise_in_n,
    output logic fault_clear_in_n,
    output logic main_power_on,
    output logic [2:0] shown_code
);
    // contacts start open, so the drive sees servo off and no clear request
    initial begin
        energise_in_n = 1'b1;
        fault_clear_in_n = 1'b1;
        main_power_on = 1'b0;
        shown_code = 3'h0;
    end

    // contacts move only just after an edge, like a real controller output scan
    always @(posedge clk_sys) begin
        energise_in_n <= ~want_on;
        fault_clear_in_n <= ~want_clear;
        main_power_on <= servo_fault_out;
        shown_code <= {fault_code_line_c, fault_code_line_b, fault_code_line_a};
    end
endmodule : host_ctrl_model

// File: sim/test_servo_alarm_seq.sv
// self-checking bench for the servo protective sequence
`timescale 1ns/10ps
`include "servo_alarm_params.svh"
module test_servo_alarm_seq;
    logic clk_sys;
    logic rstn;
    logic [15:0] alarm_cause;
    logic panel_clear_req;
    logic panel_link_fault;
    logic want_on;
    logic want_clear;
    logic fault_clear_in_n;
    logic energise_in_n;
    logic [`REG_ADDR_W-1:0] reg_addr;
    logic [`REG_DATA_W-1:0] reg_wdata;
    logic [`REG_DATA_W-1:0] reg_rdata;
    logic [31:0] rd;
    logic reg_wr;
    logic reg_rd;
    logic line_a;
    logic line_b;
    logic line_c;
    logic servo_fault_out;
    logic motor_energise;
    logic panel_fault_display;
    logic main_power_on;
    logic [2:0] shown_code;
    logic [2:0] exp;
    logic [15:0] rnd;
    int mismatches;
    int samples_checked;
    int exp_q[$];

    ////////////////////////////////////////////////////////////////////////////////
    servo_alarm_seq servo_alarm_seq_i (
        .clk_sys(clk_sys), .rstn(rstn), .alarm_cause(alarm_cause),
        .panel_clear_req(panel_clear_req), .panel_link_fault(panel_link_fault),
        .fault_clear_in_n(fault_clear_in_n), .energise_in_n(energise_in_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fault_code_line_a(line_a), .fault_code_line_b(line_b),
        .fault_code_line_c(line_c), .servo_fault_out(servo_fault_out),
        .motor_energise(motor_energise), .panel_fault_display(panel_fault_display)
    );

    host_ctrl_model host_ctrl_model_i (
        .clk_sys(clk_sys), .want_on(want_on), .want_clear(want_clear),
        .servo_fault_out(servo_fault_out), .fault_code_line_a(line_a),
        .fault_code_line_b(line_b), .fault_code_line_c(line_c),
        .energise_in_n(energise_in_n), .fault_clear_in_n(fault_clear_in_n),
        .main_power_on(main_power_on), .shown_code(shown_code)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // reference code table kept apart from the design's constants
    function automatic logic [2:0] exp_code(input int i);
        case (i)
            `CAUSE_PARAM, `CAUSE_ABS_ENC, `CAUSE_REF_READ: return 3'h0;
            `CAUSE_OVERCUR, `CAUSE_DRV_HOT: return 3'h1;
            `CAUSE_REGEN, `CAUSE_POS_OVF: return 3'h3;
            `CAUSE_OVERVOLT: return 3'h4;
            `CAUSE_OVERSPEED, `CAUSE_OVERRUN, `CAUSE_ENC_OPEN: return 3'h5;
            `CAUSE_OVERLOAD, `CAUSE_SINK_HOT: return 3'h7;
            default: return 3'h2;
        endcase
    endfunction : exp_code

    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            $display("unexpected at %0t ns: got %h expected %h", $time, got, want);
            mismatches++;
        end
    endtask : check

    // bounded wait on the alarm line (sel 0) or the motor enable (sel 1)
    task automatic wait_out(input int sel, input logic v);
        int n;
        n = 0;
        #1;
        while (((sel == 0) ? servo_fault_out : motor_energise) !== v) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 30) begin
                mismatches++;
                give_verdict();
            end
        end
    endtask : wait_out

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    function automatic logic [31:0] code_word();
        return {29'h0, line_c, line_b, line_a};
    endfunction : code_word

    ////////////////////////////////////////////////////////////////////////////////
    // free-running control clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // main sequence: power-up, servo-on, every alarm cause, panel fault, mid-run reset
    initial begin
        rstn = 1'b0;
        alarm_cause = 16'h0;
        panel_clear_req = 1'b0;
        panel_link_fault = 1'b0;
        want_on = 1'b0;
        want_clear = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        void'($urandom(32'h5D2918EC));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 check(code_word(), 32'h0);
        check({31'h0, servo_fault_out}, 32'h1);
        check({31'h0, motor_energise}, 32'h0);
        reg_read(`REG_CTRL, rd);
        check(rd, 32'h0);
        reg_read(8'h0C, rd);
        check(rd, 32'h0);
        // servo-on pin honoured, then bypass forces the motor on
        @(posedge clk_sys);
        want_on <= 1'b1;
        wait_out(1, 1'b1);
        @(posedge clk_sys);
        want_on <= 1'b0;
        wait_out(1, 1'b0);
        reg_write(`REG_CTRL, 32'h1);
        wait_out(1, 1'b1);
        reg_read(`REG_CTRL, rd);
        check(rd, 32'h1);
        // alarm latch for every cause, bypass still set on the first: motor must drop anyway
        @(posedge clk_sys);
        want_on <= 1'b1;
        for (int i = 0; i < `CAUSE_COUNT; i++) begin
            @(posedge clk_sys);
            alarm_cause <= 16'h1 << i;
            exp_q.push_back(int'(exp_code(i)));
            @(posedge clk_sys);
            rnd = 16'($urandom());
            alarm_cause <= rnd;
            exp = 3'(exp_q.pop_front());
            #1 check(code_word(), {29'h0, exp});
            check({30'h0, servo_fault_out, motor_energise}, 32'h0);
            @(posedge clk_sys);
            alarm_cause <= 16'h0;
            #1 check(code_word(), {29'h0, exp});
            check({28'h0, main_power_on, shown_code}, {29'h0, exp});
            reg_read(`REG_STATUS, rd);
            check(rd, {28'h0, 1'b1, exp});
            reg_read(`REG_CAUSE, rd);
            check(rd, {16'h0, rnd | (16'h1 << i)});
            if (i == 0) begin
                reg_write(`REG_CTRL, 32'h0);
            end
            @(posedge clk_sys);
            if (i % 2 == 1) begin
                want_clear <= 1'b1;
            end else begin
                panel_clear_req <= 1'b1;
                @(posedge clk_sys);
                panel_clear_req <= 1'b0;
            end
            wait_out(0, 1'b1);
            @(posedge clk_sys);
            want_clear <= 1'b0;
            #1 check(code_word(), 32'h0);
            wait_out(1, 1'b1);
            reg_read(`REG_STATUS, rd);
            check(rd, 32'h30);
            repeat (8) @(posedge clk_sys);
        end
        // panel link fault only shows on the panel flag
        panel_link_fault <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 check({29'h0, panel_fault_display, servo_fault_out, line_a}, 32'h6);
        check(code_word(), 32'h0);
        @(posedge clk_sys);
        panel_link_fault <= 1'b0;
        alarm_cause <= 16'h1 << `CAUSE_OVERVOLT;
        @(posedge clk_sys);
        alarm_cause <= 16'h0;
        #1 check(code_word(), 32'h4);
        // a standing cause relatches
        @(posedge clk_sys);
        alarm_cause <= 16'h1 << `CAUSE_OVERCUR;
        panel_clear_req <= 1'b1;
        @(posedge clk_sys);
        panel_clear_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 check(code_word(), 32'h1);
        // control power drop in mid-alarm discards the latch
        @(posedge clk_sys);
        rstn <= 1'b0;
        alarm_cause <= 16'h0;
        #1 check({28'h0, servo_fault_out, line_c, line_b, line_a}, 32'h8);
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        wait_out(1, 1'b1);
        check(code_word(), 32'h0);
        check({31'h0, main_power_on}, 32'h1);
        give_verdict();
    end
endmodule : test_servo_alarm_seq
